// *** core/cip_pkg.sv ***
// Shared constants and types of the interrupt prioritizer
package cip_pkg;
  // Source counts and vector numbering
  localparam int NUM_NMI = 2;
  localparam int NUM_IRQ = 16;
  localparam int IRQ_IDX_W = 4;
  localparam logic [7:0] NMI_VEC0 = 8'h01;
  localparam logic [7:0] IRQ_VEC0 = 8'h03;
  localparam logic [7:0] NO_ELEVATED = 8'h00;
  // Compact table slots
  localparam logic [7:0] CT_SLOT_NMI = 8'h01;
  localparam logic [7:0] CT_SLOT_HIGH = 8'h02;
  localparam logic [7:0] CT_SLOT_NORMAL = 8'h03;
  // Device build options
  localparam logic SMALL_FLASH = 1'b1;
  localparam logic PC_WIDE = 1'b0;
  localparam logic [15:0] VEC_WORDS = SMALL_FLASH ? 16'h0001 : 16'h0002;
  // First control register field positions
  localparam int VSEL_BIT = 6;
  localparam int CTE_BIT = 5;
  localparam int RPE_BIT = 0;
  // Change protection key and window, key value arbitrary
  localparam logic [7:0] IO_REGISTER_KEY = 8'h5a;
  localparam logic [2:0] PROT_WINDOW = 3'h4;
  // Reset values
  localparam logic [7:0] LPV_RESET = 8'h00;
  localparam logic [7:0] EVN_RESET = 8'h00;
  // Cycle counts of entry and return
  localparam logic [2:0] FINISH_CYC = 3'h1;
  localparam logic [2:0] PUSH_CYC = 3'h2;
  localparam logic [2:0] WAKE_CYC = 3'h5;
  localparam logic [2:0] ABS_JUMP_CYC = 3'h3;
  localparam logic [2:0] REL_JUMP_CYC = 3'h2;
  localparam logic [2:0] RET_SHORT_CYC = 3'h4;
  localparam logic [2:0] RET_LONG_CYC = 3'h5;
  localparam logic [2:0] JUMP_CYC = SMALL_FLASH ? REL_JUMP_CYC : ABS_JUMP_CYC;
  localparam logic [2:0] RET_CYC = PC_WIDE ? RET_LONG_CYC : RET_SHORT_CYC;

  // Control bits
  typedef struct packed {
    logic vector_base_select;
    logic compact_table_enable;
    logic rotating_priority_enable;
  } cip_ctrl_t;

  // Executing-level flags
  typedef struct packed {
    logic nonmaskable_executing;
    logic high_level_executing;
    logic normal_level_executing;
  } cip_status_t;

  // Arbitration result
  typedef struct packed {
    logic hit;
    logic [IRQ_IDX_W-1:0] idx;
  } cip_pick_t;

  // Entry and return sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_FINISH, ST_WAKE, ST_PUSH, ST_JUMP, ST_RET
  } cip_state_t;
endpackage : cip_pkg

// *** core/cip_prioritizer.sv ***
// Three-level interrupt prioritizer with entry and return sequencing
`timescale 1ns/1ps
// Function
// - Taking an interrupt never clears the peripheral's own flag.
// - Vector base select bit chooses the vector table base.
// - Base select 0 uses application section start, 1 uses boot section start.
// - Awake response takes three cycles: finish instruction, then two push cycles.
// - Vector jump lasts three cycles absolute, two relative on small flash.
// - A multicycle instruction completes before the interrupt is served.
// - Wake from sleep adds five cycles to the response.
// - Return takes four or five cycles depending on counter width.
// - High level preempts normal handler; normal resumes after high returns.
// - Three levels: non-maskable, one optional high vector, then normal.
// - Elevated vector number names the high vector; zero disables high level.
// - Non-maskable taken regardless of global enable, never changes it.
// - Nothing preempts a running non-maskable handler.
// - Simultaneous non-maskable requests served lowest vector first.
// - Static order; lowest-priority vector resets to zero, vector one highest.
// - Writing Y makes Y lowest and Y+1 highest, wrapping around.
// - Round robin writes each acknowledged normal vector as lowest priority.
// - Compact table: non-maskable at 1, high at 2, all normal at 3.
// - Protected bits change only within four instructions after the key write.
// - Compact table enable is also key protected.
// - Level flags set while running or preempted, clear on return.
// - Controller halts with the CPU in debug halt, runs otherwise.
module cip_prioritizer
  import cip_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Peripheral requests
  input wire logic [cip_pkg::NUM_IRQ-1:0] irq_req,
  input wire logic [cip_pkg::NUM_NMI-1:0] nmi_req,
  // CPU state
  input wire logic global_enable,
  input wire logic instr_boundary,
  input wire logic instr_retire,
  input wire logic cpu_sleeping,
  input wire logic return_from_interrupt,
  input wire logic debug_halt,
  // Section starts
  input wire logic [15:0] app_section_start,
  input wire logic [15:0] boot_section_start,
  // Configuration writes
  input wire logic ccp_wr,
  input wire logic [7:0] ccp_data,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_data,
  input wire logic lpv_wr,
  input wire logic [7:0] lpv_data,
  input wire logic evn_wr,
  input wire logic [7:0] evn_data,
  // Entry and return to the CPU
  output logic entry_busy,
  output logic push_pc,
  output logic vector_valid,
  output logic [15:0] vector_addr,
  output logic ack,
  output logic [7:0] ack_vector,
  output logic ret_busy,
  // State readback
  output cip_pkg::cip_ctrl_t ctrl,
  output cip_pkg::cip_status_t status,
  output logic [7:0] lowest_priority_vector,
  output logic [7:0] elevated_vector_number
);
  import cip_pkg::*;

  // Vector number of a normal request line
  function automatic logic [7:0] vec_of(input logic [IRQ_IDX_W-1:0] idx);
    vec_of = IRQ_VEC0 + {4'h0, idx};
  endfunction : vec_of

  // Rotating search: line after lpv ranks first, lpv ranks last
  function automatic cip_pick_t pick_l0(input logic [NUM_IRQ-1:0] req,
                                        input logic [7:0] lpv);
    logic [7:0] best;
    logic [7:0] key;
    pick_l0 = '0;
    best = 8'hff;
    key = 8'h00;
    for (int i = 0; i < NUM_IRQ; i++) begin
      key = vec_of(IRQ_IDX_W'(i)) - lpv - 8'h01;
      if (req[i] && (!pick_l0.hit || key < best)) begin
        pick_l0.hit = 1'b1;
        pick_l0.idx = IRQ_IDX_W'(i);
        best = key;
      end
    end
  endfunction : pick_l0

  cip_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic woke_reg, woke_next;
  cip_status_t st_reg, st_next;
  logic [7:0] lpv_reg, lpv_next;
  logic [7:0] evn_reg, evn_next;
  logic [15:0] vaddr_reg, vaddr_next;
  logic [7:0] avec_reg, avec_next;
  logic ack_reg, ack_next;

  logic [NUM_IRQ-1:0] high_mask;
  logic [NUM_IRQ-1:0] normal_req;
  logic high_req;
  cip_pick_t l0_pick;
  logic [7:0] nmi_vec;
  logic can_take, take_nmi, take_l1, take_l0, take_any, ret_ok;
  logic [7:0] take_vec, take_slot;
  logic [15:0] base;

  // Control bits; base select and compact table key protected
  cip_prot_unit cip_prot_unit_inst (
    .clk(clk),
    .rst(rst),
    .halt(debug_halt),
    .instr_retire(instr_retire),
    .ccp_wr(ccp_wr),
    .ccp_data(ccp_data),
    .ctrl_wr(ctrl_wr),
    .ctrl_data(ctrl_data),
    .ctrl(ctrl)
  );

  // Split requests into high and normal levels
  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      high_mask[i] = (evn_reg != NO_ELEVATED) && (vec_of(IRQ_IDX_W'(i)) == evn_reg);
    end
    high_req = |(irq_req & high_mask);
    normal_req = irq_req & ~high_mask;
    l0_pick = pick_l0(normal_req, lpv_reg);
  end

  // Fixed order among non-maskable lines, lowest vector wins
  always_comb begin
    nmi_vec = NMI_VEC0;
    for (int i = NUM_NMI - 1; i >= 0; i--) begin
      if (nmi_req[i]) begin
        nmi_vec = NMI_VEC0 + 8'(i);
      end
    end
  end

  // Acceptance only at an instruction boundary while idle
  assign can_take = state_reg == ST_IDLE && instr_boundary && !debug_halt;
  assign take_nmi = can_take && (|nmi_req) && !st_reg.nonmaskable_executing;
  assign take_l1 = can_take && !take_nmi && global_enable && high_req
                   && !st_reg.nonmaskable_executing && !st_reg.high_level_executing;
  assign take_l0 = can_take && !take_nmi && !take_l1 && global_enable && l0_pick.hit
                   && !st_reg.nonmaskable_executing && !st_reg.high_level_executing
                   && !st_reg.normal_level_executing;
  assign take_any = take_nmi || take_l1 || take_l0;
  assign ret_ok = state_reg == ST_IDLE && return_from_interrupt && !debug_halt
                  && (|st_reg);

  // Vector number and table slot of the winner
  always_comb begin
    take_vec = vec_of(l0_pick.idx);
    take_slot = ctrl.compact_table_enable ? CT_SLOT_NORMAL : take_vec;
    if (take_nmi) begin
      take_vec = nmi_vec;
      take_slot = ctrl.compact_table_enable ? CT_SLOT_NMI : nmi_vec;
    end else if (take_l1) begin
      take_vec = evn_reg;
      take_slot = ctrl.compact_table_enable ? CT_SLOT_HIGH : evn_reg;
    end
  end

  assign base = ctrl.vector_base_select ? boot_section_start : app_section_start;

  // Sequencer, level flags and priority registers
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    woke_next = woke_reg;
    st_next = st_reg;
    lpv_next = lpv_reg;
    evn_next = evn_reg;
    vaddr_next = vaddr_reg;
    avec_next = avec_reg;
    ack_next = 1'b0;
    if (!debug_halt) begin
      if (lpv_wr) begin
        lpv_next = lpv_data;
      end
      if (evn_wr) begin
        evn_next = evn_data;
      end
      case (state_reg)
        ST_IDLE: begin
          if (take_any) begin
            // Peripheral flags are left alone; only the level flag is set
            state_next = ST_FINISH;
            cnt_next = FINISH_CYC - 3'h1;
            woke_next = cpu_sleeping;
            vaddr_next = base + 16'({8'h00, take_slot}) * VEC_WORDS;
            avec_next = take_vec;
            ack_next = 1'b1;
            if (take_nmi) begin
              st_next.nonmaskable_executing = 1'b1;
            end else if (take_l1) begin
              st_next.high_level_executing = 1'b1;
            end else begin
              st_next.normal_level_executing = 1'b1;
              if (ctrl.rotating_priority_enable) begin
                lpv_next = take_vec;
              end
            end
          end else if (ret_ok) begin
            state_next = ST_RET;
            cnt_next = RET_CYC - 3'h1;
          end
        end
        ST_FINISH: begin
          if (woke_reg) begin
            state_next = ST_WAKE;
            cnt_next = WAKE_CYC - 3'h1;
          end else begin
            state_next = ST_PUSH;
            cnt_next = PUSH_CYC - 3'h1;
          end
        end
        ST_WAKE: begin
          if (cnt_reg == 3'h0) begin
            state_next = ST_PUSH;
            cnt_next = PUSH_CYC - 3'h1;
          end else begin
            cnt_next = cnt_reg - 3'h1;
          end
        end
        ST_PUSH: begin
          if (cnt_reg == 3'h0) begin
            state_next = ST_JUMP;
            cnt_next = JUMP_CYC - 3'h1;
          end else begin
            cnt_next = cnt_reg - 3'h1;
          end
        end
        ST_JUMP: begin
          if (cnt_reg == 3'h0) begin
            state_next = ST_IDLE;
          end else begin
            cnt_next = cnt_reg - 3'h1;
          end
        end
        ST_RET: begin
          if (cnt_reg == 3'h0) begin
            state_next = ST_IDLE;
            // Innermost level returns; outer flags resume
            if (st_reg.nonmaskable_executing) begin
              st_next.nonmaskable_executing = 1'b0;
            end else if (st_reg.high_level_executing) begin
              st_next.high_level_executing = 1'b0;
            end else begin
              st_next.normal_level_executing = 1'b0;
            end
          end else begin
            cnt_next = cnt_reg - 3'h1;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      woke_reg <= 1'b0;
      st_reg <= '0;
      lpv_reg <= LPV_RESET;
      evn_reg <= EVN_RESET;
      vaddr_reg <= 16'h0000;
      avec_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      woke_reg <= woke_next;
      st_reg <= st_next;
      lpv_reg <= lpv_next;
      evn_reg <= evn_next;
      vaddr_reg <= vaddr_next;
      avec_reg <= avec_next;
      ack_reg <= ack_next;
    end
  end

  // Outputs
  assign entry_busy = state_reg inside {ST_FINISH, ST_WAKE, ST_PUSH, ST_JUMP};
  assign push_pc = state_reg == ST_PUSH;
  assign vector_valid = state_reg == ST_JUMP;
  assign ret_busy = state_reg == ST_RET;
  assign vector_addr = vaddr_reg;
  assign ack = ack_reg;
  assign ack_vector = avec_reg;
  assign status = st_reg;
  assign lowest_priority_vector = lpv_reg;
  assign elevated_vector_number = evn_reg;

  // Entry and return checks
  sequence s_gap3;
    !vector_valid [*3];
  endsequence
  sequence s_gap8;
    !vector_valid [*8];
  endsequence

  chk_awake_response: assert property (@(posedge clk) disable iff (rst || debug_halt)
    (take_any && !cpu_sleeping) |-> ##1 s_gap3 ##1 vector_valid)
    else $error("awake response not three cycles");
  chk_wake_response: assert property (@(posedge clk) disable iff (rst || debug_halt)
    (take_any && cpu_sleeping) |-> ##1 s_gap8 ##1 vector_valid)
    else $error("wake response not eight cycles");
  chk_jump_length: assert property (@(posedge clk) disable iff (rst || debug_halt)
    $rose(vector_valid) |-> vector_valid [*2] ##1 (vector_valid == !SMALL_FLASH)
      ##1 !vector_valid)
    else $error("vector jump length wrong");
  chk_return_length: assert property (@(posedge clk) disable iff (rst || debug_halt)
    ret_ok |=> ret_busy [*4] ##1 (ret_busy == PC_WIDE) ##1 (!PC_WIDE || !ret_busy))
    else $error("return length wrong");
  chk_nmi_ignores_gie: assert property (@(posedge clk) disable iff (rst)
    (can_take && !global_enable && (|nmi_req) && !st_reg.nonmaskable_executing)
      |=> ack && status.nonmaskable_executing)
    else $error("nmi not taken with global enable low");
  chk_nmi_no_preempt: assert property (@(posedge clk) disable iff (rst)
    st_reg.nonmaskable_executing |-> !ack_next || ret_busy)
    else $error("nmi handler preempted");
  chk_rr_update: assert property (@(posedge clk) disable iff (rst)
    (take_l0 && ctrl.rotating_priority_enable) |=> lowest_priority_vector == ack_vector)
    else $error("round robin did not record vector");
  chk_elevated_off: assert property (@(posedge clk) disable iff (rst)
    (evn_reg == NO_ELEVATED) |-> !take_l1)
    else $error("high level taken while disabled");
  chk_high_nests: assert property (@(posedge clk) disable iff (rst)
    (take_l1 && st_reg.normal_level_executing)
      |=> status.high_level_executing && status.normal_level_executing)
    else $error("normal flag lost on preemption");
  chk_boundary_only: assert property (@(posedge clk) disable iff (rst)
    $rose(entry_busy) |-> $past(instr_boundary) && $past(ack_next))
    else $error("entry began off an instruction boundary");
  chk_compact_slot: assert property (@(posedge clk) disable iff (rst)
    (take_l0 && ctrl.compact_table_enable)
      |=> vector_addr == $past(base) + 16'({8'h00, CT_SLOT_NORMAL}) * VEC_WORDS)
    else $error("compact normal vector address wrong");
endmodule : cip_prioritizer

// *** core/cip_prot_unit.sv ***
// First control register; base select and compact table bits change protected
`timescale 1ns/1ps
module cip_prot_unit
  import cip_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic halt,
  // CPU instruction progress
  input wire logic instr_retire,
  // Key and control writes
  input wire logic ccp_wr,
  input wire logic [7:0] ccp_data,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_data,
  // Control bits
  output cip_pkg::cip_ctrl_t ctrl
);
  import cip_pkg::*;

  logic [2:0] win_reg, win_next;
  cip_ctrl_t ctrl_reg, ctrl_next;

  // Key window and protected bit update
  always_comb begin
    win_next = win_reg;
    ctrl_next = ctrl_reg;
    if (!halt) begin
      if (ccp_wr && ccp_data == IO_REGISTER_KEY) begin
        win_next = PROT_WINDOW;
      end else if (instr_retire && win_reg != 3'h0) begin
        win_next = win_reg - 3'h1;
      end
      if (ctrl_wr) begin
        ctrl_next.rotating_priority_enable = ctrl_data[RPE_BIT];
        if (win_reg != 3'h0) begin
          ctrl_next.vector_base_select = ctrl_data[VSEL_BIT];
          ctrl_next.compact_table_enable = ctrl_data[CTE_BIT];
          win_next = 3'h0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      win_reg <= 3'h0;
      ctrl_reg <= '0;
    end else begin
      win_reg <= win_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign ctrl = ctrl_reg;

  chk_protect_guard: assert property (@(posedge clk) disable iff (rst)
    (ctrl_wr && win_reg == 3'h0) |=> $stable(ctrl_reg.vector_base_select)
      && $stable(ctrl_reg.compact_table_enable))
    else $error("protected bit changed without key");
endmodule : cip_prot_unit

// *** verif/cip_cpu_model.sv ***
// CPU side model: instruction progress seen by the prioritizer
`timescale 1ns/1ps
module cip_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Cycles per instruction, 1 to 3
  input wire logic [1:0] instr_len,
  // Sequencer activity
  input wire logic entry_busy,
  input wire logic ret_busy,
  // Instruction progress
  output logic instr_boundary,
  output logic instr_retire
);
  logic [1:0] cnt;
  logic last;

  // Known levels before the first edge
  initial begin
    cnt = 2'h0;
    instr_boundary = 1'b0;
    instr_retire = 1'b0;
  end

  // Last cycle of the current instruction
  assign last = (cnt == instr_len - 2'h1);

  // No instruction completes while the entry or return sequence runs
  always @(posedge clk) begin
    if (rst || entry_busy || ret_busy) begin
      cnt <= 2'h0;
      instr_boundary <= 1'b0;
      instr_retire <= 1'b0;
    end else begin
      cnt <= last ? 2'h0 : cnt + 2'h1;
      instr_boundary <= last;
      instr_retire <= last; // Each one counts in the key window
    end
  end
endmodule : cip_cpu_model

// *** verif/cip_prioritizer_tb.sv ***
// Self-checking bench of the interrupt prioritizer
`timescale 1ns/1ps
module cip_prioritizer_tb;
  import cip_pkg::*;
  localparam logic [15:0] APP = 16'h0200;
  localparam logic [15:0] BOOT = 16'h0040;
  localparam int GAP_AWAKE = int'(FINISH_CYC) + int'(PUSH_CYC);
  localparam int GAP_SLEEP = GAP_AWAKE + int'(WAKE_CYC);
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_IRQ-1:0] irq_req = '0;
  logic [NUM_NMI-1:0] nmi_req = '0;
  logic global_enable = 1'b0;
  logic cpu_sleeping = 1'b0;
  logic return_from_interrupt = 1'b0;
  logic debug_halt = 1'b0;
  logic ccp_wr = 1'b0;
  logic [7:0] ccp_data = 8'h00;
  logic ctrl_wr = 1'b0;
  logic [7:0] ctrl_data = 8'h00;
  logic lpv_wr = 1'b0;
  logic [7:0] lpv_data = 8'h00;
  logic evn_wr = 1'b0;
  logic [7:0] evn_data = 8'h00;
  logic [1:0] instr_len = 2'h1;
  logic instr_boundary, instr_retire, entry_busy, push_pc, vector_valid, ack, ret_busy;
  logic [15:0] vector_addr;
  logic [7:0] ack_vector, lowest_priority_vector, elevated_vector_number;
  cip_ctrl_t ctrl;
  cip_status_t status;
  int num_errors = 0;
  int cmp_count = 0;

  // Clock
  always #5 clk = ~clk;

  // Design and CPU model
  cip_prioritizer cip_prioritizer_inst (.clk, .rst, .irq_req, .nmi_req, .global_enable,
    .instr_boundary, .instr_retire, .cpu_sleeping, .return_from_interrupt, .debug_halt,
    .app_section_start(APP), .boot_section_start(BOOT), .ccp_wr, .ccp_data, .ctrl_wr,
    .ctrl_data, .lpv_wr, .lpv_data, .evn_wr, .evn_data, .entry_busy, .push_pc,
    .vector_valid, .vector_addr, .ack, .ack_vector, .ret_busy, .ctrl, .status,
    .lowest_priority_vector, .elevated_vector_number);
  cip_cpu_model cip_cpu_model_inst (.clk, .rst, .instr_len, .entry_busy, .ret_busy,
    .instr_boundary, .instr_retire);

  // Compare and count
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Control write, optionally after the key and a delay
  task automatic wr_ctrl(logic [7:0] d, bit key, int gap);
    if (key) begin
      ccp_wr <= 1'b1;
      ccp_data <= IO_REGISTER_KEY;
      @(posedge clk);
      ccp_wr <= 1'b0;
      repeat (gap) @(posedge clk);
    end
    ctrl_wr <= 1'b1;
    ctrl_data <= d;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    @(posedge clk);
  endtask : wr_ctrl

  // Priority register write: sel 0 lowest vector, 1 elevated vector
  task automatic wr_pri(bit sel, logic [7:0] d);
    lpv_wr <= !sel;
    evn_wr <= sel;
    lpv_data <= d;
    evn_data <= d;
    @(posedge clk);
    lpv_wr <= 1'b0;
    evn_wr <= 1'b0;
    @(posedge clk);
  endtask : wr_pri

  // Wait for a take and follow the entry sequence
  task automatic take(logic [7:0] vec, logic [15:0] base, logic [7:0] slot, int gap);
    int n;
    int np;
    logic bnd;
    n = 0;
    np = 0;
    bnd = 1'b0;
    while (ack !== 1'b1 && n < 200) begin
      bnd = instr_boundary;
      @(posedge clk);
      n++;
    end
    check("take at boundary", 16'h0001, 16'(bnd));
    check("ack vector", 16'(vec), 16'(ack_vector));
    @(posedge clk);
    check("ack pulse", 16'h0000, 16'(ack));
    check("entry busy", 16'h0001, 16'(entry_busy));
    n = 1;
    while (vector_valid !== 1'b1 && n < 20) begin
      np += int'(push_pc === 1'b1);
      @(posedge clk);
      n++;
    end
    check("entry cycles", 16'(gap), 16'(n));
    check("push cycles", 16'(PUSH_CYC), 16'(np));
    check("vector addr", base + 16'(slot) * VEC_WORDS, vector_addr);
    @(posedge clk);
    check("jump held", 16'h0001, 16'(vector_valid));
    repeat (JUMP_CYC - 3'h1) @(posedge clk);
    check("jump cycles", 16'h0000, 16'(vector_valid));
  endtask : take

  // Return from a handler and check the flags left behind
  task automatic ret(logic [2:0] st);
    int n;
    n = 0;
    return_from_interrupt <= 1'b1;
    @(posedge clk);
    return_from_interrupt <= 1'b0;
    @(posedge clk);
    while (ret_busy === 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    check("return cycles", 16'(RET_CYC), 16'(n));
    check("level flags", 16'(st), 16'(status));
  endtask : ret

  // No acknowledge for n cycles
  task automatic no_take(int n);
    repeat (n) begin
      @(posedge clk);
      check("held request", 16'h0000, 16'(ack));
    end
  endtask : no_take

  // Watchdog
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  // Test sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("ctrl reset", 16'h0000, 16'(ctrl));
    check("status reset", 16'h0000, 16'(status));
    check("lowest reset", 16'h0000, 16'(lowest_priority_vector));
    check("elevated reset", 16'h0000, 16'(elevated_vector_number));
    $display("test reset done");
    global_enable <= 1'b1; // Enabled before any configuration write
    irq_req <= 16'h0024;
    take(8'h05, APP, 8'h05, GAP_AWAKE);
    check("normal flag", 16'h0001, 16'(status));
    irq_req <= 16'h0020;
    ret(3'b000);
    take(8'h08, APP, 8'h08, GAP_AWAKE);
    irq_req <= '0;
    ret(3'b000);
    $display("test static order done");
    wr_pri(1'b0, 8'h04);
    check("lowest write", 16'h0004, 16'(lowest_priority_vector));
    irq_req <= 16'h0009;
    take(8'h06, APP, 8'h06, GAP_AWAKE);
    irq_req <= '0;
    ret(3'b000);
    $display("test moved order done");
    wr_ctrl(8'h01, 1'b0, 0);
    check("rotating bit", 16'h0001, 16'(ctrl));
    wr_pri(1'b0, 8'h00);
    irq_req <= 16'h0003;
    take(8'h03, APP, 8'h03, GAP_AWAKE);
    check("rotated lowest", 16'h0003, 16'(lowest_priority_vector));
    ret(3'b000);
    take(8'h04, APP, 8'h04, GAP_AWAKE);
    check("rotated lowest", 16'h0004, 16'(lowest_priority_vector));
    irq_req <= '0;
    ret(3'b000);
    wr_ctrl(8'h00, 1'b0, 0);
    $display("test round robin done");
    wr_pri(1'b1, 8'h07);
    check("elevated write", 16'h0007, 16'(elevated_vector_number));
    irq_req <= 16'h0001;
    take(8'h03, APP, 8'h03, GAP_AWAKE);
    irq_req <= 16'h0011;
    take(8'h07, APP, 8'h07, GAP_AWAKE);
    check("nested flags", 16'h0003, 16'(status));
    irq_req <= 16'h0001;
    ret(3'b001);
    irq_req <= '0;
    ret(3'b000);
    $display("test preemption done");
    global_enable <= 1'b0;
    irq_req <= 16'h0010;
    no_take(5);
    nmi_req <= 2'b11; // Source enabled at its peripheral
    take(8'h01, APP, 8'h01, GAP_AWAKE);
    check("nmi flag", 16'h0004, 16'(status));
    global_enable <= 1'b1;
    nmi_req <= 2'b10;
    no_take(10);
    ret(3'b000);
    take(8'h02, APP, 8'h02, GAP_AWAKE);
    nmi_req <= '0;
    ret(3'b000);
    take(8'h07, APP, 8'h07, GAP_AWAKE);
    irq_req <= '0;
    ret(3'b000);
    $display("test nonmaskable done");
    wr_ctrl(8'h60, 1'b0, 0);
    check("unkeyed write", 16'h0000, 16'(ctrl));
    wr_ctrl(8'h60, 1'b1, 6);
    check("late write", 16'h0000, 16'(ctrl));
    wr_ctrl(8'h60, 1'b1, 0);
    check("keyed write", 16'h0006, 16'(ctrl));
    $display("test protection done");
    nmi_req <= 2'b01;
    take(8'h01, BOOT, CT_SLOT_NMI, GAP_AWAKE);
    nmi_req <= '0;
    ret(3'b000);
    irq_req <= 16'h0010;
    take(8'h07, BOOT, CT_SLOT_HIGH, GAP_AWAKE);
    irq_req <= 16'h0002;
    ret(3'b000);
    take(8'h04, BOOT, CT_SLOT_NORMAL, GAP_AWAKE);
    irq_req <= '0;
    ret(3'b000);
    $display("test compact table done");
    cpu_sleeping <= 1'b1;
    irq_req <= 16'h0001;
    take(8'h03, BOOT, CT_SLOT_NORMAL, GAP_SLEEP);
    cpu_sleeping <= 1'b0;
    irq_req <= '0;
    ret(3'b000);
    $display("test wake done");
    debug_halt <= 1'b1;
    irq_req <= 16'h0001;
    no_take(10);
    debug_halt <= 1'b0;
    take(8'h03, BOOT, CT_SLOT_NORMAL, GAP_AWAKE);
    irq_req <= '0;
    ret(3'b000);
    $display("test debug halt done");
    instr_len <= 2'h3;
    irq_req <= 16'h0001;
    take(8'h03, BOOT, CT_SLOT_NORMAL, GAP_AWAKE);
    irq_req <= '0;
    ret(3'b000);
    $display("test multicycle done");
    wrap_up();
  end
endmodule : cip_prioritizer_tb
